// file: core/dcff_top.sv
`timescale 1ns/1ps
`include "dcff_regs.svh"
// Summary of operation
// - Mode pin caught at reset: low standard, high fall-through
// - Standard mode: empty and full flags show state
// - Fall-through: output-ready and input-ready flags show state
// - Fall-through: first word falls through without request
// - Low write enable stores data at write edges
// - Empty flag rises after first write
// - Almost-empty rises at empty offset plus one
// - Half-full falls above half the depth, above half plus one in fall-through
// - Almost-full falls at depth minus full offset, plus one in fall-through
// - Full flag at depth; writes blocked while full
// - Reads from full release full, almost-full, half-full
// - Almost-empty falls when count reaches empty offset, offset plus one in fall-through
// - Empty flag after last read; reads ignored empty
// - Empty and full flags pass two register stages
// - Full side flags update on write clock edges
// - Empty side flags update on read clock edges
// - Empty and full offsets are programmable registers
// - Offset defaults 127 parallel, 1,023 serial
// - Fall-through almost-empty rises at offset plus two
// - Fall-through blocks writes at depth plus one
// - Output-ready three stages, input-ready two stages
module dcff_top
  import dcff_pkg::*;
#(
  parameter int AW = `DCFF_ADDR_W,
  parameter int DW = `DCFF_DATA_W
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Write port pins
  input wire logic write_clk_i,
  input wire logic write_en_n_i,
  input wire logic [DW-1:0] data_in_i,
  // Read port pins
  input wire logic read_clk_i,
  input wire logic read_en_n_i,
  output logic [DW-1:0] data_out_o,
  // Configuration pins sampled during reset
  input wire logic timing_mode_serial_in_i,
  input wire logic load_n_i,
  // Status flags
  output logic empty_flag_n_o,
  output logic output_ready_n_o,
  output logic full_flag_n_o,
  output logic input_ready_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic half_full_flag_n_o
);

  // Pointers carry two extra bits so depth plus one is countable
  localparam int PW = AW + 2;
  localparam int PINW = DW + 6;
  localparam logic [PW-1:0] DEPTH = PW'(1) << AW;
  localparam logic [PW-1:0] HALF = DEPTH >> 1;

  typedef struct packed {
    dcff_mode_type mode;
    logic [AW-1:0] empty_offset;
    logic [AW-1:0] full_offset;
    logic wclk_d;
    logic rclk_d;
    logic [PW-1:0] wptr;
    logic [PW-1:0] wgray;
    logic nf_s1;
    logic nf_s2;
    logic af_n;
    logic hf_n;
    logic [PW-1:0] raddr;
    logic [PW-1:0] cptr;
    logic [PW-1:0] cgray;
    logic ovalid;
    logic ne_s1;
    logic ne_s2;
    logic or_s1;
    logic or_s2;
    logic or_s3;
    logic ae_n;
    logic [DW-1:0] dout;
    logic ack;
    logic [31:0] rdat;
  } dcff_state_type;

  dcff_state_type st;
  dcff_state_type next_st;

  logic [PINW-1:0] pin_raw;
  logic [PINW-1:0] pin_s;
  logic [PW-1:0] wgray_s;
  logic [PW-1:0] cgray_s;
  logic [DW-1:0] mem_rdata;
  logic wclk_s;
  logic rclk_s;
  logic wen_s;
  logic ren_s;
  logic mode_s;
  logic load_s;
  logic [DW-1:0] din_s;
  logic wedge;
  logic redge;
  logic fall_through_mode;
  logic [PW-1:0] ext;
  logic [PW-1:0] cap;
  logic [PW-1:0] wsync_bin;
  logic [PW-1:0] csync_bin;
  logic [PW-1:0] wcnt;
  logic [PW-1:0] wcnt_n;
  logic [PW-1:0] rcnt_n;
  logic [PW-1:0] ram_cnt;
  logic full_now;
  logic wr;
  logic rd_std;
  logic consume;
  logic fetch;
  logic bus_wr;

  function automatic logic [PW-1:0] gray_to_bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Every pin input passes two flip-flops before use
  assign pin_raw = {load_n_i, timing_mode_serial_in_i, read_en_n_i, read_clk_i, write_en_n_i, write_clk_i, data_in_i};

  dcff_sync #(.W(PINW)) u_pin_sync (
    .clk_i(clk_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  assign din_s = pin_s[DW-1:0];
  assign wclk_s = pin_s[DW];
  assign wen_s = pin_s[DW+1];
  assign rclk_s = pin_s[DW+2];
  assign ren_s = pin_s[DW+3];
  assign mode_s = pin_s[DW+4];
  assign load_s = pin_s[DW+5];

  // Gray pointers cross between the write and read sides
  dcff_sync #(.W(PW)) u_wptr_sync (
    .clk_i(clk_i),
    .d_i(st.wgray),
    .q_o(wgray_s)
  );

  dcff_sync #(.W(PW)) u_cptr_sync (
    .clk_i(clk_i),
    .d_i(st.cgray),
    .q_o(cgray_s)
  );

  dcff_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk_i(clk_i),
    .we_i(wr),
    .waddr_i(st.wptr[AW-1:0]),
    .wdata_i(din_s),
    .raddr_i(st.raddr[AW-1:0]),
    .rdata_o(mem_rdata)
  );

  // Edges of the sampled port clocks and shared arithmetic
  assign wedge = wclk_s & ~st.wclk_d;
  assign redge = rclk_s & ~st.rclk_d;
  assign fall_through_mode = (st.mode == DCFF_FALL_THROUGH);
  assign ext = fall_through_mode ? PW'(1) : PW'(0);
  assign cap = DEPTH + ext;
  assign wsync_bin = gray_to_bin(wgray_s);
  assign csync_bin = gray_to_bin(cgray_s);
  assign wcnt = st.wptr - csync_bin;
  assign full_now = (wcnt >= cap);
  assign wr = wedge & ~wen_s & ~full_now;
  assign wcnt_n = wcnt + PW'(wr);
  assign ram_cnt = wsync_bin - st.raddr;
  // Standard reads need a request and a presented not-empty flag
  assign rd_std = ~fall_through_mode & redge & ~ren_s & st.ne_s2;
  assign consume = fall_through_mode & redge & ~ren_s & st.or_s3;
  // The head word falls into the output register unrequested
  assign fetch = fall_through_mode & redge & (ram_cnt != '0) & (~st.ovalid | consume);
  assign rcnt_n = wsync_bin - (st.cptr + PW'(rd_std | consume));
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & st.ack;

  // Next-state logic for both port sides and the bus slave
  always_comb begin
    next_st = st;
    next_st.wclk_d = wclk_s;
    next_st.rclk_d = rclk_s;
    // Write side: flags change only at write clock edges
    if (wedge) begin
      next_st.wptr = st.wptr + PW'(wr);
      next_st.wgray = next_st.wptr ^ (next_st.wptr >> 1);
      // Own writes assert full at once; release waits two stages
      next_st.nf_s1 = (wcnt_n < cap);
      next_st.nf_s2 = st.nf_s1 & (wcnt_n < cap);
      next_st.af_n = ~(wcnt_n >= cap - PW'(st.full_offset));
      next_st.hf_n = ~(wcnt_n > HALF + ext);
    end
    // Read side: flags change only at read clock edges
    if (redge) begin
      next_st.raddr = st.raddr + PW'(rd_std | fetch);
      next_st.cptr = st.cptr + PW'(rd_std | consume);
      next_st.cgray = next_st.cptr ^ (next_st.cptr >> 1);
      if (rd_std | fetch) begin
        next_st.dout = mem_rdata;
      end
      if (fetch) begin
        next_st.ovalid = 1'b1;
      end else if (consume) begin
        next_st.ovalid = 1'b0;
      end
      // Own reads assert empty at once; new data waits the stages
      next_st.ne_s1 = (rcnt_n != '0);
      next_st.ne_s2 = st.ne_s1 & (rcnt_n != '0);
      next_st.or_s1 = next_st.ovalid;
      next_st.or_s2 = st.or_s1 & next_st.ovalid;
      next_st.or_s3 = st.or_s2 & next_st.ovalid;
      next_st.ae_n = ~(rcnt_n <= PW'(st.empty_offset) + ext);
    end
    // Bus slave answers one cycle after the request
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
    if (wb_cyc_i & wb_stb_i & ~st.ack) begin
      next_st.rdat = '0;
      unique case (wb_adr_i)
        `DCFF_EMPTY_OFFSET_ADR: begin
          next_st.rdat[AW-1:0] = st.empty_offset;
        end
        `DCFF_FULL_OFFSET_ADR: begin
          next_st.rdat[AW-1:0] = st.full_offset;
        end
        `DCFF_STATUS_ADR: begin
          next_st.rdat[`DCFF_ST_EMPTY_N] = empty_flag_n_o;
          next_st.rdat[`DCFF_ST_FULL_N] = full_flag_n_o;
          next_st.rdat[`DCFF_ST_OUT_READY_N] = output_ready_n_o;
          next_st.rdat[`DCFF_ST_IN_READY_N] = input_ready_n_o;
          next_st.rdat[`DCFF_ST_ALMOST_EMPTY_N] = st.ae_n;
          next_st.rdat[`DCFF_ST_ALMOST_FULL_N] = st.af_n;
          next_st.rdat[`DCFF_ST_HALF_FULL_N] = st.hf_n;
          next_st.rdat[`DCFF_ST_FALL_THROUGH] = fall_through_mode;
        end
        default: begin
          next_st.rdat = '0; // Unmapped reads return zero
        end
      endcase
    end
    // Offsets take the write at the acknowledge edge, byte by byte
    if (bus_wr && wb_adr_i == `DCFF_EMPTY_OFFSET_ADR) begin
      for (int b = 0; b < AW; b++) begin
        if (wb_sel_i[b/8]) begin
          next_st.empty_offset[b] = wb_dat_i[b];
        end
      end
    end
    if (bus_wr && wb_adr_i == `DCFF_FULL_OFFSET_ADR) begin
      for (int b = 0; b < AW; b++) begin
        if (wb_sel_i[b/8]) begin
          next_st.full_offset[b] = wb_dat_i[b];
        end
      end
    end
    // Master reset clears pointers and catches mode and load pins
    if (rst_i) begin
      next_st = '0;
      next_st.wclk_d = wclk_s;
      next_st.rclk_d = rclk_s;
      next_st.mode = mode_s ? DCFF_FALL_THROUGH : DCFF_STANDARD;
      next_st.empty_offset = load_s ? AW'(`DCFF_OFFSET_SERIAL_DEF) : AW'(`DCFF_OFFSET_PARALLEL_DEF);
      next_st.full_offset = load_s ? AW'(`DCFF_OFFSET_SERIAL_DEF) : AW'(`DCFF_OFFSET_PARALLEL_DEF);
      next_st.nf_s1 = 1'b1;
      next_st.nf_s2 = 1'b1;
      next_st.af_n = 1'b1;
      next_st.hf_n = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // Outputs; the flags of the inactive mode rest high
  assign data_out_o = st.dout;
  assign empty_flag_n_o = fall_through_mode ? 1'b1 : st.ne_s2;
  assign output_ready_n_o = fall_through_mode ? ~st.or_s3 : 1'b1;
  assign full_flag_n_o = fall_through_mode ? 1'b1 : st.nf_s2;
  assign input_ready_n_o = fall_through_mode ? ~st.nf_s2 : 1'b1;
  assign almost_empty_flag_n_o = st.ae_n;
  assign almost_full_flag_n_o = st.af_n;
  assign half_full_flag_n_o = st.hf_n;
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;

  // Checks on the block's own behaviour
  sequence s_read_req;
    redge && !ren_s;
  endsequence

  sequence s_empty_view;
    !fall_through_mode && !st.ne_s2;
  endsequence

  property p_mode_latch;
    @(posedge clk_i) $fell(rst_i) |-> (fall_through_mode == $past(mode_s));
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not caught from pin at reset");

  property p_write_store;
    @(posedge clk_i) disable iff (rst_i) (wedge && !wen_s && !full_now) |=> (st.wptr == $past(st.wptr) + PW'(1));
  endproperty
  a_write_store: assert property (p_write_store) else $error("enabled write not stored");

  property p_full_block;
    @(posedge clk_i) disable iff (rst_i) (wedge && wcnt >= cap) |=> $stable(st.wptr);
  endproperty
  a_full_block: assert property (p_full_block) else $error("write taken while full");

  property p_empty_ignore;
    @(posedge clk_i) disable iff (rst_i) (s_empty_view ##0 s_read_req) |=> ($stable(st.raddr) && $stable(st.dout));
  endproperty
  a_empty_ignore: assert property (p_empty_ignore) else $error("read acted while empty");

  property p_full_flag;
    @(posedge clk_i) disable iff (rst_i) (!fall_through_mode && wedge && wcnt_n >= DEPTH) |=> !full_flag_n_o;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag not low at depth");

  property p_empty_two_stage;
    @(posedge clk_i) disable iff (rst_i) (!fall_through_mode && $rose(st.ne_s2)) |-> $past(st.ne_s1);
  endproperty
  a_empty_two_stage: assert property (p_empty_two_stage) else $error("empty flag skipped a stage");

  property p_ready_three_stage;
    @(posedge clk_i) disable iff (rst_i) (fall_through_mode && $rose(st.or_s3)) |-> ($past(st.or_s2) && st.ovalid);
  endproperty
  a_ready_three_stage: assert property (p_ready_three_stage) else $error("output ready skipped a stage");

  property p_half_full;
    @(posedge clk_i) disable iff (rst_i) (wedge && wcnt_n > HALF + ext) |=> !half_full_flag_n_o;
  endproperty
  a_half_full: assert property (p_half_full) else $error("half-full not low above half");

  property p_almost_empty;
    @(posedge clk_i) disable iff (rst_i) (redge && rcnt_n <= PW'(st.empty_offset) + ext) |=> !almost_empty_flag_n_o;
  endproperty
  a_almost_empty: assert property (p_almost_empty) else $error("almost-empty not low at offset");

  property p_fall_through;
    @(posedge clk_i) disable iff (rst_i) (fall_through_mode && redge && ram_cnt != '0 && !st.ovalid) |=> st.ovalid;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("head word did not fall through");

endmodule

// file: core/dcff_regs.svh
`ifndef DCFF_REGS_SVH
`define DCFF_REGS_SVH

// Register byte offsets on the bus
`define DCFF_EMPTY_OFFSET_ADR 8'h00
`define DCFF_FULL_OFFSET_ADR 8'h04
`define DCFF_STATUS_ADR 8'h08

// Status register field positions
`define DCFF_ST_EMPTY_N 0
`define DCFF_ST_FULL_N 1
`define DCFF_ST_OUT_READY_N 2
`define DCFF_ST_IN_READY_N 3
`define DCFF_ST_ALMOST_EMPTY_N 4
`define DCFF_ST_ALMOST_FULL_N 5
`define DCFF_ST_HALF_FULL_N 6
`define DCFF_ST_FALL_THROUGH 7

// Offset defaults chosen by the load-select pin at reset
`define DCFF_OFFSET_PARALLEL_DEF 16'h007F
`define DCFF_OFFSET_SERIAL_DEF 16'h03FF

// Documented organisation: 8,192 words of 18 bits
`define DCFF_ADDR_W 13
`define DCFF_DATA_W 18

`endif

// file: core/dcff_pkg.sv
package dcff_pkg;

  // Timing mode, one-hot
  typedef enum logic [1:0] {
    DCFF_STANDARD = 2'b01,
    DCFF_FALL_THROUGH = 2'b10
  } dcff_mode_type;

endpackage

// file: core/dcff_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser; the first stage feeds only the second
module dcff_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dcff_sync_type;

  dcff_sync_type st;
  dcff_sync_type next_st;

  // Shift the two stages; no reset, the stages flush in two edges
  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign q_o = st.s2;

endmodule

// file: core/dcff_mem.sv
`timescale 1ns/1ps
// Storage array: one write port, one asynchronous read port
module dcff_mem #(
  parameter int AW = 13,
  parameter int DW = 18
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Memory contents need no reset; pointers define what is valid
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule

// file: test/dcff_stream_model.sv
`timescale 1ns/1ps
// Producer and consumer logic on the pin ports; both clocks stand low between transfers
module dcff_stream_model (
  // System
  input wire logic clk_i,
  // Producer side
  output logic write_clk_o,
  output logic write_en_n_o,
  output logic [17:0] data_in_o,
  // Consumer side
  output logic read_clk_o,
  output logic read_en_n_o
);
  // Idle levels at time zero
  initial begin
    write_clk_o = 1'b0;
    write_en_n_o = 1'b1;
    data_in_o = 18'h00000;
    read_clk_o = 1'b0;
    read_en_n_o = 1'b1;
  end

  // One 160 ns write clock period: 80 ns before the rise, 60 ns high, which covers the pin sampling delay
  // Returns at the falling system edge so the caller sees settled flags
  task automatic wr_edge(input logic en, input logic [17:0] d);
    @(posedge clk_i);
    write_en_n_o <= ~en;
    data_in_o <= d;
    repeat (4) @(posedge clk_i);
    write_clk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    write_clk_o <= 1'b0;
    write_en_n_o <= 1'b1;
    data_in_o <= ~d; // Released bus must not look like a held word
    @(negedge clk_i);
  endtask

  // One 160 ns read clock period; the enable is driven low only when en is set
  task automatic rd_edge(input logic en);
    @(posedge clk_i);
    read_en_n_o <= ~en;
    repeat (4) @(posedge clk_i);
    read_clk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    read_clk_o <= 1'b0;
    read_en_n_o <= 1'b1;
    @(negedge clk_i);
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Small depth keeps a full fill short
  localparam int AW = 5;
  localparam int DEPTH = 32;
  localparam int N_OFF = 4;
  localparam int M_OFF = 5;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic write_clk, write_en_n, read_clk, read_en_n;
  logic [17:0] data_in, data_out;
  logic mode_pin = 1'b0;
  logic load_n = 1'b1;
  logic empty_n, out_ready_n, full_n, in_ready_n, ae_n, af_n, hf_n;
  int err_total = 0;
  int checks_done = 0;
  logic [17:0] exp_q[$];

  always #10 clk_i = ~clk_i;

  dcff_top #(.AW(AW)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .write_clk_i(write_clk), .write_en_n_i(write_en_n), .data_in_i(data_in),
    .read_clk_i(read_clk), .read_en_n_i(read_en_n), .data_out_o(data_out), .timing_mode_serial_in_i(mode_pin),
    .load_n_i(load_n), .empty_flag_n_o(empty_n), .output_ready_n_o(out_ready_n), .full_flag_n_o(full_n),
    .input_ready_n_o(in_ready_n), .almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n),
    .half_full_flag_n_o(hf_n));

  dcff_stream_model u_peer (.clk_i(clk_i), .write_clk_o(write_clk), .write_en_n_o(write_en_n),
    .data_in_o(data_in), .read_clk_o(read_clk), .read_en_n_o(read_en_n));

  // Comparisons
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t value got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; waits for ack, bounded
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (t >= 50) begin
      err_total++;
      $display("[ERR] %0t bus cycle got no ack", $time);
    end
  endtask

  // Mode and load pins stay steady for the whole reset
  task automatic reset_dut(input logic mode, input logic ld);
    mode_pin <= mode;
    load_n <= ld;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Gives both sides enough own-clock edges to pass the flag stages
  task automatic settle();
    repeat (2) u_peer.wr_edge(1'b0, 18'h15555);
    repeat (4) u_peer.rd_edge(1'b0);
  endtask

  // Expected flags for k stored words; f is the fall-through mode
  task automatic chk_flags(input int k, input logic f);
    int cap;
    cap = DEPTH + f;
    if (!f) begin
      chk_flag(empty_n, k > 0);
      chk_flag(full_n, k < cap);
      chk_flag(out_ready_n & in_ready_n, 1'b1);
    end else begin
      chk_flag(out_ready_n, k == 0);
      chk_flag(in_ready_n, k >= cap);
      chk_flag(empty_n & full_n, 1'b1);
    end
    chk_flag(ae_n, k > N_OFF + f);
    chk_flag(hf_n, k <= DEPTH / 2 + f);
    chk_flag(af_n, k < cap - M_OFF);
  endtask

  // Fill to refusal, then drain to empty, checking flags at every count
  task automatic run_mode(input logic f);
    int k;
    logic [17:0] last;
    logic [31:0] q;
    for (k = 1; k <= DEPTH + f; k++) begin
      exp_q.push_back(18'h20000 | 18'(k));
      u_peer.wr_edge(1'b1, 18'h20000 | 18'(k));
      settle();
      chk_flags(k, f);
      if (k == 1) chk_val({14'h0000, data_out}, f ? 32'h00020001 : 32'h00000000);
    end
    u_peer.wr_edge(1'b1, 18'h3FFFF);
    settle();
    chk_flags(DEPTH + f, f);
    for (k = DEPTH + f; k >= 1; k--) begin
      last = exp_q.pop_front();
      if (f) chk_val({14'h0000, data_out}, {14'h0000, last});
      u_peer.rd_edge(1'b1);
      if (!f) chk_val({14'h0000, data_out}, {14'h0000, last});
      settle();
      chk_flags(k - 1, f);
    end
    // Reads while empty move nothing
    u_peer.rd_edge(1'b1);
    settle();
    chk_flags(0, f);
    if (!f) chk_val({14'h0000, data_out}, {14'h0000, last});
    wb_cycle(1'b0, 8'h08, 32'h0, q);
    chk_val(q & 32'h000000FF, f ? 32'h000000E7 : 32'h0000006E);
  endtask

  // Offsets are written; the full offset and an unmapped address are read back
  task automatic set_offsets();
    logic [31:0] q;
    wb_cycle(1'b1, 8'h00, N_OFF, q);
    wb_cycle(1'b1, 8'h04, M_OFF, q);
    wb_cycle(1'b0, 8'h04, 32'h0, q);
    chk_val(q, M_OFF);
    wb_cycle(1'b0, 8'h0C, 32'h0, q);
    chk_val(q, 32'h00000000);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence: standard mode with serial defaults, then fall-through with parallel defaults
  initial begin
    logic [31:0] q;
    // Offset registers are AW bits wide in this small build, so defaults are cut to that width
    reset_dut(1'b0, 1'b1);
    wb_cycle(1'b0, 8'h00, 32'h0, q);
    chk_val(q, 32'h000003FF & ((32'h1 << AW) - 32'h1));
    wb_cycle(1'b0, 8'h04, 32'h0, q);
    chk_val(q, 32'h000003FF & ((32'h1 << AW) - 32'h1));
    set_offsets();
    run_mode(1'b0);
    reset_dut(1'b1, 1'b0);
    wb_cycle(1'b0, 8'h00, 32'h0, q);
    chk_val(q, 32'h0000007F & ((32'h1 << AW) - 32'h1));
    wb_cycle(1'b0, 8'h04, 32'h0, q);
    chk_val(q, 32'h0000007F & ((32'h1 << AW) - 32'h1));
    set_offsets();
    run_mode(1'b1);
    wrap_up();
  end

  // Watchdog well beyond the expected run of about 7,600 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
